/* File: core/refmon_pkg.sv */
package refmon_pkg;
  localparam int NUM_REFS = 8;
  localparam int NUM_PROF = 8;
  localparam int PROF_SEL_W = 3;
  localparam int PERIOD_W = 50;
  localparam int TOL_W = 20;
  localparam int MS_W = 16;
  localparam int SYSCLK_W = 32;
  localparam int ADDR_W = 16;
  localparam int TICK_ACC_W = 41;
  localparam logic [ADDR_W-1:0] FORCE_VALID_ADDR = 16'h0A0E;
  localparam logic [NUM_REFS-1:0] FORCE_RESET = 8'h00;
  localparam logic [NUM_REFS-1:0] FAULT_RESET = 8'hFF;
  // one millisecond in femtoseconds
  localparam logic [TICK_ACC_W-1:0] MS_IN_FS = 41'h0E8D4A51000;

  typedef logic [PERIOD_W-1:0] period_t;
  typedef logic [TOL_W-1:0] tol_t;
  typedef logic [MS_W-1:0] ms_t;
  typedef logic [SYSCLK_W-1:0] sysclk_t;

  // deviation times reciprocal tolerance must not exceed the nominal period
  function automatic logic within_tol(period_t meas, period_t nom, tol_t tol);
    period_t dev;
    logic [PERIOD_W+TOL_W-1:0] prod;
    dev = (meas > nom) ? meas - nom : nom - meas;
    prod = dev * tol;
    return prod <= {{TOL_W{1'b0}}, nom};
  endfunction
endpackage

/* File: core/ms_tick_gen.sv */
`timescale 1ns/100ps
module ms_tick_gen (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // programmed system clock period in fs
  input wire refmon_pkg::sysclk_t i_sysclk_period,
  // one-cycle millisecond enable
  output logic o_tick
);
  import refmon_pkg::*;
  logic [TICK_ACC_W-1:0] acc;
  logic [TICK_ACC_W-1:0] next_acc;
  logic [TICK_ACC_W-1:0] sum;
  logic next_tick;

  always_comb begin
    sum = acc + {{(TICK_ACC_W-SYSCLK_W){1'b0}}, i_sysclk_period};
    next_tick = 1'b0;
    next_acc = sum;
    if (sum >= MS_IN_FS) begin
      next_acc = sum - MS_IN_FS;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      acc <= '0;
      o_tick <= 1'b0;
    end else begin
      acc <= next_acc;
      o_tick <= next_tick;
    end
  end
endmodule

/* File: core/ref_period_meter.sv */
`timescale 1ns/100ps
module ref_period_meter (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // reference input and time base
  input wire logic i_ref,
  input wire refmon_pkg::sysclk_t i_sysclk_period,
  // measurement results
  output logic o_sample,
  output refmon_pkg::period_t o_period,
  output refmon_pkg::period_t o_running
);
  import refmon_pkg::*;
  logic ref_d;
  logic armed;
  logic next_armed;
  logic next_sample;
  period_t next_period;
  period_t next_running;
  logic [PERIOD_W:0] sum;

  always_comb begin
    sum = {1'b0, o_running} + {{(PERIOD_W+1-SYSCLK_W){1'b0}}, i_sysclk_period};
    next_running = sum[PERIOD_W] ? '1 : sum[PERIOD_W-1:0];
    next_period = o_period;
    next_sample = 1'b0;
    next_armed = armed;
    // rising edge closes one period and opens the next
    if (i_ref && !ref_d) begin
      next_armed = 1'b1;
      next_sample = armed;
      next_period = armed ? next_running : o_period;
      // the new period starts empty; each following cycle adds one system period
      next_running = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ref_d <= 1'b0;
      armed <= 1'b0;
      o_sample <= 1'b0;
      o_period <= '0;
      o_running <= '0;
    end else begin
      ref_d <= i_ref;
      armed <= next_armed;
      o_sample <= next_sample;
      o_period <= next_period;
      o_running <= next_running;
    end
  end
endmodule

/* File: core/reference_monitor_validation.sv */
`timescale 1ns/100ps
module reference_monitor_validation (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // reference inputs
  input wire logic [refmon_pkg::NUM_REFS-1:0] i_ref,
  // system clock state
  input wire refmon_pkg::sysclk_t i_sysclk_period,
  input wire logic i_sysclk_stable,
  // profile write port
  input wire logic i_prof_wr,
  input wire logic [refmon_pkg::PROF_SEL_W-1:0] i_prof_sel,
  input wire refmon_pkg::period_t i_prof_period,
  input wire refmon_pkg::tol_t i_prof_inner,
  input wire refmon_pkg::tol_t i_prof_outer,
  input wire refmon_pkg::ms_t i_prof_valid_ms,
  input wire refmon_pkg::ms_t i_prof_redet_ms,
  // reference-to-profile assignment
  input wire logic [refmon_pkg::NUM_REFS-1:0] i_assign_en,
  input wire logic [refmon_pkg::NUM_REFS*refmon_pkg::PROF_SEL_W-1:0] i_assign_prof,
  input wire logic [refmon_pkg::NUM_REFS-1:0] i_auto_sel,
  // validation override controls
  input wire logic [refmon_pkg::NUM_REFS-1:0] i_mon_bypass,
  input wire logic [refmon_pkg::NUM_REFS-1:0] i_mon_override,
  // register write port
  input wire logic i_reg_wr,
  input wire logic [refmon_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [refmon_pkg::NUM_REFS-1:0] i_reg_wdata,
  // status
  output logic [refmon_pkg::NUM_REFS-1:0] o_valid,
  output logic [refmon_pkg::NUM_REFS-1:0] o_faulted,
  output logic [refmon_pkg::NUM_REFS-1:0] o_ref_fault,
  output logic [refmon_pkg::NUM_REFS-1:0] o_redetect
);
  import refmon_pkg::*;

  // write strobe that lands on the force register
  function automatic logic force_strobe(logic wr, logic [ADDR_W-1:0] addr);
    return wr && addr == FORCE_VALID_ADDR;
  endfunction

  // millisecond counter step, shared by both timers
  function automatic ms_t ms_inc(ms_t c);
    return c + 16'h0001;
  endfunction

  logic ms_tick;
  logic [NUM_REFS-1:0] sample;
  period_t meas [NUM_REFS];
  period_t running [NUM_REFS];

  ms_tick_gen u_tick (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_sysclk_period(i_sysclk_period),
    .o_tick(ms_tick)
  );

  for (genvar g = 0; g < NUM_REFS; g++) begin : g_meter
    ref_period_meter u_meter (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_ref(i_ref[g]),
      .i_sysclk_period(i_sysclk_period),
      .o_sample(sample[g]),
      .o_period(meas[g]),
      .o_running(running[g])
    );
  end

  // profile storage
  period_t prof_period [NUM_PROF];
  tol_t prof_inner [NUM_PROF];
  tol_t prof_outer [NUM_PROF];
  ms_t prof_valid [NUM_PROF];
  ms_t prof_redet [NUM_PROF];
  period_t next_prof_period [NUM_PROF];
  tol_t next_prof_inner [NUM_PROF];
  tol_t next_prof_outer [NUM_PROF];
  ms_t next_prof_valid [NUM_PROF];
  ms_t next_prof_redet [NUM_PROF];

  always_comb begin
    for (int p = 0; p < NUM_PROF; p++) begin
      next_prof_period[p] = prof_period[p];
      next_prof_inner[p] = prof_inner[p];
      next_prof_outer[p] = prof_outer[p];
      next_prof_valid[p] = prof_valid[p];
      next_prof_redet[p] = prof_redet[p];
    end
    if (i_prof_wr) begin
      next_prof_period[i_prof_sel] = i_prof_period;
      next_prof_inner[i_prof_sel] = i_prof_inner;
      next_prof_outer[i_prof_sel] = i_prof_outer;
      next_prof_valid[i_prof_sel] = i_prof_valid_ms;
      next_prof_redet[i_prof_sel] = i_prof_redet_ms;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      for (int p = 0; p < NUM_PROF; p++) begin
        prof_period[p] <= '0;
        prof_inner[p] <= '0;
        prof_outer[p] <= '0;
        prof_valid[p] <= '0;
        prof_redet[p] <= '0;
      end
    end else begin
      prof_period <= next_prof_period;
      prof_inner <= next_prof_inner;
      prof_outer <= next_prof_outer;
      prof_valid <= next_prof_valid;
      prof_redet <= next_prof_redet;
    end
  end

  // per-input monitor, validation and redetect state
  logic [NUM_REFS-1:0] force_pend;
  logic [NUM_REFS-1:0] expire;
  ms_t val_cnt [NUM_REFS];
  ms_t redet_cnt [NUM_REFS];
  logic [NUM_REFS-1:0] next_force;
  logic [NUM_REFS-1:0] next_valid;
  logic [NUM_REFS-1:0] next_faulted;
  logic [NUM_REFS-1:0] next_ref_fault;
  logic [NUM_REFS-1:0] next_redetect;
  ms_t next_val_cnt [NUM_REFS];
  ms_t next_redet_cnt [NUM_REFS];

  always_comb begin
    logic [PROF_SEL_W-1:0] p;
    period_t nom;
    ms_t vms;
    ms_t rms;
    p = '0;
    nom = '0;
    vms = '0;
    rms = '0;
    next_force = '0;
    if (force_strobe(i_reg_wr, i_reg_addr)) begin
      next_force = i_reg_wdata;
    end
    for (int i = 0; i < NUM_REFS; i++) begin
      p = i_assign_prof[i*PROF_SEL_W +: PROF_SEL_W];
      nom = prof_period[p];
      vms = prof_valid[p];
      rms = prof_redet[p];
      // internal monitor fault with inner/outer hysteresis
      next_ref_fault[i] = o_ref_fault[i];
      if (!i_sysclk_stable || !i_assign_en[i]) begin
        next_ref_fault[i] = 1'b1;
      end else if (sample[i]) begin
        if (o_ref_fault[i]) begin
          next_ref_fault[i] = !within_tol(meas[i], nom, prof_inner[p]);
        end else begin
          next_ref_fault[i] = !within_tol(meas[i], nom, prof_outer[p]);
        end
      end else if (!o_ref_fault[i] && running[i] > nom
                   && !within_tol(running[i], nom, prof_outer[p])) begin
        // missing edge: the open period already exceeds the outer window
        next_ref_fault[i] = 1'b1;
      end
      // effective fault from override controls
      if (!i_assign_en[i]) begin
        next_faulted[i] = 1'b1;
      end else if (i_mon_bypass[i]) begin
        next_faulted[i] = i_mon_override[i];
      end else begin
        next_faulted[i] = i_mon_override[i] | next_ref_fault[i];
      end
      // validation timer
      expire[i] = ms_tick && !o_faulted[i] && vms != '0 && ms_inc(val_cnt[i]) == vms;
      next_val_cnt[i] = val_cnt[i];
      if (o_faulted[i]) begin
        next_val_cnt[i] = '0;
      end else if (ms_tick && vms != '0 && val_cnt[i] < vms) begin
        next_val_cnt[i] = ms_inc(val_cnt[i]);
      end
      // valid latch
      next_valid[i] = o_valid[i];
      if (o_faulted[i]) begin
        next_valid[i] = 1'b0;
      end else if (expire[i] || force_pend[i]) begin
        next_valid[i] = !o_faulted[i];
      end
      // redetect timer
      next_redetect[i] = 1'b0;
      next_redet_cnt[i] = redet_cnt[i];
      if (!o_faulted[i] || !i_auto_sel[i] || rms == '0) begin
        next_redet_cnt[i] = '0;
      end else if (ms_tick) begin
        if (ms_inc(redet_cnt[i]) == rms) begin
          next_redetect[i] = 1'b1;
          next_redet_cnt[i] = '0;
        end else begin
          next_redet_cnt[i] = ms_inc(redet_cnt[i]);
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      force_pend <= FORCE_RESET;
      o_valid <= '0;
      o_faulted <= FAULT_RESET;
      o_ref_fault <= FAULT_RESET;
      o_redetect <= '0;
      for (int i = 0; i < NUM_REFS; i++) begin
        val_cnt[i] <= '0;
        redet_cnt[i] <= '0;
      end
    end else begin
      force_pend <= next_force;
      o_valid <= next_valid;
      o_faulted <= next_faulted;
      o_ref_fault <= next_ref_fault;
      o_redetect <= next_redetect;
      val_cnt <= next_val_cnt;
      redet_cnt <= next_redet_cnt;
    end
  end

  // profile of input 0, looked up by the checks below
  logic [PROF_SEL_W-1:0] prof0;
  assign prof0 = i_assign_prof[PROF_SEL_W-1:0];

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  stab_fault_hold_a: assert property (!i_sysclk_stable |=> o_ref_fault == '1)
    else $error("monitor not faulted before system clock stable");
  fault_kills_valid_a: assert property ((o_valid & $past(o_faulted)) == '0)
    else $error("valid high after faulted");
  rise_resets_timer_a: assert property ($rose(o_faulted[0]) |=> val_cnt[0] == '0)
    else $error("validation timer not reset on fault rise");
  timer_held_a: assert property (o_faulted[0] [*2] |-> val_cnt[0] == '0)
    else $error("validation timer ran while faulted");
  expiry_validates_a: assert property (expire[0] |=> o_valid[0])
    else $error("expiry did not set valid");
  bypass_follows_a: assert property (i_mon_bypass[0] && i_assign_en[0]
      |=> o_faulted[0] == $past(i_mon_override[0]))
    else $error("bypass fault not following override");
  override_forces_a: assert property (!i_mon_bypass[0] && i_mon_override[0]
      |=> o_faulted[0])
    else $error("override did not force fault");
  force_selfclear_a: assert property (force_pend[0]
      && !(force_strobe(i_reg_wr, i_reg_addr) && i_reg_wdata[0]) |=> !force_pend[0])
    else $error("force bit did not self-clear");
  force_loads_a: assert property (force_pend[0] && !o_faulted[0] |=> o_valid[0])
    else $error("force did not load valid latch");
  unassigned_invalid_a: assert property (!i_assign_en[0] |=> o_faulted[0] ##1 !o_valid[0])
    else $error("unassigned input not invalid");
  unassigned_fault_a: assert property (!i_assign_en[0] |=> o_ref_fault[0])
    else $error("unassigned input monitor not faulted");
  stab_gate_a: assert property (!i_sysclk_stable && !i_mon_bypass[0] |=> o_faulted[0])
    else $error("effective fault low before system clock stable");
  force_refused_a: assert property (force_pend[0] && o_faulted[0] |=> !o_valid[0])
    else $error("force validated a faulted input");

  // monitor and effective fault
  sample_pulse_a: assert property (sample[0] |=> !sample[0])
    else $error("measurement strobe longer than one cycle");
  clear_on_sample_a: assert property ($fell(o_ref_fault[0]) |-> $past(sample[0]))
    else $error("monitor fault cleared without a measurement");
  default_follow_a: assert property (!i_mon_bypass[0] && !i_mon_override[0]
      && i_assign_en[0] |=> o_faulted[0] == o_ref_fault[0])
    else $error("effective fault differs from monitor fault");
  valid_drop_a: assert property ($fell(o_valid[0]) |-> $past(o_faulted[0]))
    else $error("valid dropped without a fault");

  // timers
  tick_single_a: assert property (ms_tick |=> !ms_tick)
    else $error("millisecond tick longer than one cycle");
  count_on_tick_a: assert property (!o_faulted[0] && !ms_tick |=> $stable(val_cnt[0]))
    else $error("validation timer moved without a tick");
  disabled_valid_a: assert property (prof_valid[prof0] == '0 && !force_pend[0]
      && !o_valid[0] |=> !o_valid[0])
    else $error("disabled timer validated an input");
  redet_off_a: assert property (prof_redet[prof0] == '0 |=> !o_redetect[0])
    else $error("redetect pulse with timer disabled");
  redet_manual_a: assert property (!i_auto_sel[0] |=> !o_redetect[0])
    else $error("redetect pulse without automatic selection");
  redet_cause_a: assert property (o_redetect[0]
      |-> $past(o_faulted[0]) && $past(ms_tick))
    else $error("redetect pulse without a faulted tick");

  // profile storage
  prof_store_a: assert property (i_prof_wr && i_prof_sel == 3'h0
      |=> prof_period[0] == $past(i_prof_period) && prof_inner[0] == $past(i_prof_inner))
    else $error("profile write not stored");

  valid_rise_c: cover property ($rose(o_valid[0]));
  redetect_c: cover property (o_redetect[0]);
  force_valid_c: cover property (force_pend[0] ##1 o_valid[0]);
  fault_recover_c: cover property ($fell(o_ref_fault[0]));
  override_c: cover property (i_mon_override[0] ##1 o_faulted[0]);
endmodule

/* File: tb/ref_clock_sources.sv */
`timescale 1ns/100ps
module ref_clock_sources (
  // clock
  input wire logic i_ref_clk,
  // per-input period in clock cycles, zero stops that source
  input wire logic [7:0][5:0] i_period,
  // reference clock lines
  output logic [7:0] o_ref
);
  logic [7:0][5:0] cnt;
  initial begin
    cnt = '0;
    o_ref = 8'h00;
  end
  always @(negedge i_ref_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (i_period[i] == 6'h00) begin
        // stopped source: the receiver pull-down holds the line low
        cnt[i] <= 6'h00;
        o_ref[i] <= 1'b0;
      end else begin
        cnt[i] <= (cnt[i] + 6'h01 >= i_period[i]) ? 6'h00 : cnt[i] + 6'h01;
        o_ref[i] <= (cnt[i] < (i_period[i] >> 1));
      end
    end
  end
endmodule

/* File: tb/reference_monitor_validation_tb.sv */
`timescale 1ns/100ps
module reference_monitor_validation_tb;
  import refmon_pkg::*;
  // 4e9 fs system period: one millisecond is 250 cycles
  localparam sysclk_t SCLK = 32'hEE6B2800;
  // nominal period of 20 cycles
  localparam period_t NOM = 50'h12A05F2000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic stable = 1'b0;
  logic prof_wr = 1'b0;
  logic [2:0] prof_sel = 3'h0;
  period_t prof_period = '0;
  tol_t prof_inner = '0;
  tol_t prof_outer = '0;
  ms_t prof_valid = '0;
  ms_t prof_redet = '0;
  logic [7:0] assign_en = 8'h00;
  logic [23:0] assign_prof = 24'h000000;
  logic [7:0] auto_sel = 8'h00;
  logic [7:0] bypass = 8'h00;
  logic [7:0] override = 8'h00;
  logic reg_wr = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0][5:0] per = {8{6'h14}};
  logic [7:0] refs;
  logic [7:0] valid;
  logic [7:0] faulted;
  logic [7:0] ref_fault;
  logic [7:0] redetect;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'h037fa9d2;
  int p;
  int n3;
  int nother;
  always #5 clk = ~clk;
  ref_clock_sources src (.i_ref_clk(clk), .i_period(per), .o_ref(refs));
  reference_monitor_validation dut (.i_ref_clk(clk), .i_rstn(rstn), .i_ref(refs),
    .i_sysclk_period(SCLK), .i_sysclk_stable(stable), .i_prof_wr(prof_wr),
    .i_prof_sel(prof_sel), .i_prof_period(prof_period), .i_prof_inner(prof_inner),
    .i_prof_outer(prof_outer), .i_prof_valid_ms(prof_valid), .i_prof_redet_ms(prof_redet),
    .i_assign_en(assign_en), .i_assign_prof(assign_prof), .i_auto_sel(auto_sel),
    .i_mon_bypass(bypass), .i_mon_override(override), .i_reg_wr(reg_wr),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_valid(valid), .o_faulted(faulted),
    .o_ref_fault(ref_fault), .o_redetect(redetect));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic prof(input logic [2:0] s, input tol_t inr, input tol_t otr, input ms_t v,
                      input ms_t r);
    prof_sel = s;
    prof_period = NOM;
    prof_inner = inr;
    prof_outer = otr;
    prof_valid = v;
    prof_redet = r;
    prof_wr = 1'b1;
    cyc(1);
    prof_wr = 1'b0;
    cyc(1);
  endtask
  task automatic regw(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic wait_valid(input logic [7:0] m, input int lim);
    int k;
    for (k = 0; k < lim && (valid & m) !== m; k++) cyc(1);
    if (k == lim) begin
      $display("BAD wait for valid mask %h", m);
      n_errors++;
      final_report();
    end
  endtask
  // outer window of 1/20 on a 20-cycle nominal allows one cycle of deviation
  function automatic logic exp_outer_fault(input int prd);
    return (prd > 21) || (prd < 19);
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    rstn = 1'b1;
    chk("reset valid", 8'h00, valid);
    chk("reset faulted", FAULT_RESET, faulted);
    chk("reset ref_fault", 8'hFF, ref_fault);
    chk("reset redetect", 8'h00, redetect);
    prof(3'h0, 20'd100, 20'd20, 16'd2, 16'd1);
    prof(3'h1, 20'd100, 20'd20, 16'd0, 16'd0);
    assign_en = 8'h7F;
    assign_prof = 24'h040000;
    auto_sel = 8'h48;
    cyc(300);
    chk("unstable faulted", 8'hFF, faulted);
    stable = 1'b1;
    cyc(150);
    chk("monitor fault", 8'h80, ref_fault);
    chk("effective fault", 8'h80, faulted);
    wait_valid(8'h3F, 800);
    chk("valid after timer", 8'h3F, valid);
    regw(16'h0A0F, 8'h40);
    cyc(3);
    chk("other address ignored", 8'h3F, valid);
    regw(FORCE_VALID_ADDR, 8'hC0);
    cyc(2);
    chk("forced valid", 8'h7F, valid);
    per[4] = 6'h00;
    bypass = 8'h12;
    override = 8'h03;
    cyc(100);
    chk("stalled monitor", 8'h90, ref_fault);
    chk("override faulted", 8'h83, faulted);
    chk("override valid", 8'h7C, valid);
    bypass = 8'h13;
    cyc(5);
    chk("bypass override", 8'h83, faulted);
    override = 8'h00;
    bypass = 8'h00;
    per[4] = 6'h14;
    cyc(300);
    chk("timer restarted", 8'h6C, valid);
    wait_valid(8'h13, 800);
    per[2] = 6'h16;
    cyc(150);
    chk("outer exceeded", 8'h84, ref_fault);
    per[2] = 6'h15;
    cyc(150);
    chk("inner not met", 8'h84, ref_fault);
    per[2] = 6'h14;
    cyc(150);
    chk("inner met", 8'h80, ref_fault);
    for (int t = 0; t < 4; t++) begin
      p = 20 + ($random(seed) % 4);
      per[5] = 6'(p);
      cyc(150);
      chk("random period", {2'b10, exp_outer_fault(p), 5'h00}, ref_fault);
      per[5] = 6'h14;
      cyc(150);
    end
    per[3] = 6'h00;
    per[5] = 6'h00;
    per[6] = 6'h00;
    n3 = 0;
    nother = 0;
    // let the stopped inputs fault first, then count over four milliseconds
    cyc(100);
    for (int k = 0; k < 1000; k++) begin
      cyc(1);
      if (redetect[3] === 1'b1) n3++;
      if ((redetect & 8'hF7) !== 8'h00) nother++;
    end
    chk("redetect pulses", 8'h04, 8'(n3));
    chk("no other redetect", 8'h00, 8'(nother));
    final_report();
  end
endmodule
